// *** hw/sipo_latch_pkg.sv ***
// Purpose: Shared constants for the serial-in, parallel-out latched shifter
// Assumes: One core clock; all pins sampled on it
// Notes:   Widths are fixed, not parameters of the top
package sipo_latch_pkg;
  localparam int         STAGES      = 8;
  localparam int         FIFO_WORDS  = 32;
  localparam logic [7:0] SHIFT_RESET = 8'h00;
  localparam logic [7:0] STORE_RESET = 8'h00;
  localparam int         LAST_STAGE  = STAGES - 1;
endpackage

// *** hw/snapshot_fifo_if.sv ***
// Purpose: Carrier between the shifter core and its snapshot FIFO
// Assumes: Both ends on core_clk
// Notes:   A word moves when valid and ready are both high
`timescale 1ns/1ps
`default_nettype none
interface snapshot_fifo_if #(parameter int WIDTH = 8);
  logic             wrValid;
  logic             wrReady;
  logic [WIDTH-1:0] wrData;
  logic             rdValid;
  logic             rdReady;
  logic [WIDTH-1:0] rdData;
  modport core (output wrValid, wrData, rdReady, input wrReady, rdValid, rdData);
  modport fifo (input wrValid, wrData, rdReady, output wrReady, rdValid, rdData);
endinterface
`default_nettype wire

// *** hw/snapshot_fifo.sv ***
// Purpose: Show-ahead FIFO holding latched shift snapshots
// Assumes: DEPTH is a power of two
// Notes:   Full and empty come from an occupancy count
`timescale 1ns/1ps
`default_nettype none
module snapshot_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic   core_clk,
  input  wire logic   rst,
  // Queue ports
  snapshot_fifo_if.fifo q
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_reg;
  logic [AW-1:0]    rdPtr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign q.wrReady = (count_reg != (AW+1)'(DEPTH));
  assign q.rdValid = (count_reg != '0);
  assign q.rdData  = mem[rdPtr_reg];
  assign push      = q.wrValid && q.wrReady;
  assign pop       = q.rdValid && q.rdReady;

  // Storage array carries no reset
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr_reg] <= q.wrData;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wrPtr_reg <= wrPtr_reg + AW'(1);
      end
      if (pop) begin
        rdPtr_reg <= rdPtr_reg + AW'(1);
      end
      if (push && !pop) begin
        count_reg <= count_reg + (AW+1)'(1);
      end else if (pop && !push) begin
        count_reg <= count_reg - (AW+1)'(1);
      end
    end
  end
endmodule
`default_nettype wire

// *** hw/sipo_latched_shifter.sv ***
// Purpose: Eight-stage serial-in shifter feeding a storage register with gated outputs
// Assumes: Shift and latch clocks arrive as levels synchronous to core_clk
// Notes:   Snapshots pass through a FIFO so the output side may hold off updates
//
// How it works
// (R1) Eight shift stages feed an eight-bit storage register of the same width.
// (R2) Shift and storage registers each move only on a rising edge of their own clock input; storage loads on dequeue, which latchHold can delay.
// (R3) On a shift edge with clear inactive, each stage takes its predecessor and stage 0 takes the data input.
// (R4) On a latch edge with clear inactive, all eight stages are copied toward the storage register.
// (R5) Clear low empties the shift register regardless of the shift clock, so the cascade output reads zero.
// (R6) The last shift stage is presented on the cascade output for chaining.
// (R7) The storage register drives eight three-state outputs, stage 0 on the first output.
// (R8) While the active-low output enable is high, all eight outputs are released.
// (R9) With both clocks tied, the storage register lags the shift register by one pulse.
// (R10) Clear leaves storage and outputs alone until a later latch edge moves the cleared contents; older queued snapshots still load during clear.
// (R11) Output enable gates only the output drivers, never the registers or the cascade output.
`timescale 1ns/1ps
`default_nettype none
module sipo_latched_shifter
  import sipo_latch_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // Serial side
  input  wire logic              data_in_line,
  input  wire logic              shift_clock,
  input  wire logic              latch_clock,
  input  wire logic              shift_clear_n,
  input  wire logic              outEnable_n,
  output logic                   cascadeOut,
  // Parallel side, two signals per pin
  output logic [STAGES-1:0]      parallelOut,
  output logic [STAGES-1:0]      parallelOe,
  // Flow control of the snapshot queue
  input  wire logic              latchHold,
  output logic                   latchReady
);
  logic [STAGES-1:0] shift_reg;
  logic [STAGES-1:0] store_reg;
  logic              shiftClkPrev_reg;
  logic              latchClkPrev_reg;
  logic              oe_reg;
  logic              latchReady_reg;
  logic              shiftEdge;
  logic              latchEdge;

  snapshot_fifo_if #(.WIDTH(STAGES)) q ();

  snapshot_fifo #(
    .WIDTH (STAGES),
    .DEPTH (FIFO_WORDS)
  ) u_fifo (
    .core_clk (core_clk),
    .rst      (rst),
    .q        (q.fifo)
  );

  // (R2) Rising edges only
  assign shiftEdge = shift_clock && !shiftClkPrev_reg;
  assign latchEdge = latch_clock && !latchClkPrev_reg;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shiftClkPrev_reg <= 1'b0;
      latchClkPrev_reg <= 1'b0;
    end else begin
      shiftClkPrev_reg <= shift_clock;
      latchClkPrev_reg <= latch_clock;
    end
  end

  // (R5) Clear overrides shifting
  // (R3) Shift toward last stage
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shift_reg <= SHIFT_RESET;
    end else if (!shift_clear_n) begin
      shift_reg <= SHIFT_RESET;
    end else if (shiftEdge) begin
      shift_reg <= {shift_reg[LAST_STAGE-1:0], data_in_line};
    end
  end

  // (R6) Cascade from last stage
  assign cascadeOut = shift_reg[LAST_STAGE];

  // (R4) Snapshot on latch edge
  // (R9) Old contents taken, giving the lag
  // A full queue drops the edge; latchReady follows wrReady one core_clk cycle late
  assign q.wrValid = latchEdge && shift_clear_n;
  assign q.wrData  = shift_reg;
  assign q.rdReady = !latchHold;

  // (R1) Storage of equal width
  // (R10) Only a dequeued snapshot changes it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      store_reg <= STORE_RESET;
    end else if (q.rdValid && q.rdReady) begin
      store_reg <= q.rdData;
    end
  end

  // (R7) Stage 0 on the first output
  assign parallelOut = store_reg;

  // (R8) Release all outputs
  // (R11) Only the drivers see the enable
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= !outEnable_n;
    end
  end
  assign parallelOe = {STAGES{oe_reg}};

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      latchReady_reg <= 1'b0;
    end else begin
      latchReady_reg <= q.wrReady;
    end
  end
  assign latchReady = latchReady_reg;

  a_clear_empties: assert property ( // (R5)
    @(posedge core_clk) disable iff (rst)
    !shift_clear_n |=> (shift_reg == SHIFT_RESET) && !cascadeOut)
    else $error("clear did not empty the shift register");

  a_shift_moves: assert property ( // (R3)
    @(posedge core_clk) disable iff (rst)
    shift_clear_n && shiftEdge |=> shift_reg == {$past(shift_reg[LAST_STAGE-1:0]), $past(data_in_line)})
    else $error("shift edge did not move the stages");

  a_shift_waits: assert property ( // (R2)
    @(posedge core_clk) disable iff (rst)
    shift_clear_n && !$past(rst) && !(shift_clock && !$past(shift_clock)) |=> $stable(shift_reg))
    else $error("shift register moved without a rising edge");

  a_cascade_follows: assert property ( // (R6)
    @(posedge core_clk) disable iff (rst)
    shift_clear_n && shiftEdge |=> cascadeOut == $past(shift_reg[LAST_STAGE-1]))
    else $error("cascade output did not follow the last stage");

  a_latch_copies: assert property ( // (R4)
    @(posedge core_clk) disable iff (rst)
    latchEdge && shift_clear_n && !q.rdValid |=> ##1 $past(latchHold) || parallelOut == $past(shift_reg, 2))
    else $error("latch edge did not copy the stages");

  a_tied_lag: assert property ( // (R9)
    @(posedge core_clk) disable iff (rst)
    latchEdge && shiftEdge && shift_clear_n && !q.rdValid |=> ##1
      $past(latchHold) || (parallelOut == $past(shift_reg, 2) &&
      $past(shift_reg) == {parallelOut[LAST_STAGE-1:0], $past(data_in_line, 2)}))
    else $error("storage did not lag the shift register");

  a_clear_keeps: assert property ( // (R10)
    @(posedge core_clk) disable iff (rst)
    !shift_clear_n && !q.rdValid |=> ##1 $stable(store_reg))
    else $error("clear disturbed the storage register");

  a_oe_releases: assert property ( // (R8)
    @(posedge core_clk) disable iff (rst)
    outEnable_n |=> parallelOe == '0)
    else $error("outputs driven while disabled");

  a_oe_isolated: assert property ( // (R11)
    @(posedge core_clk) disable iff (rst)
    $changed(outEnable_n) && shift_clear_n && !shiftEdge |=> $stable(shift_reg))
    else $error("output enable disturbed the shift register");

  a_oe_drives: assert property ( // (R8)
    @(posedge core_clk) disable iff (rst)
    !outEnable_n |=> parallelOe == '1)
    else $error("outputs not driven while enabled");

  a_oe_keeps_out: assert property ( // (R11)
    @(posedge core_clk) disable iff (rst)
    $changed(outEnable_n) && !q.rdValid |=> $stable(parallelOut))
    else $error("output enable disturbed the stored word");

  a_oe_keeps_cascade: assert property ( // (R11)
    @(posedge core_clk) disable iff (rst)
    $changed(outEnable_n) && shift_clear_n && !shiftEdge |=> $stable(cascadeOut))
    else $error("output enable disturbed the cascade output");

  a_latch_waits: assert property ( // (R2)
    @(posedge core_clk) disable iff (rst)
    !q.rdValid && !(latchEdge && shift_clear_n) |=> ##1 $stable(store_reg))
    else $error("storage moved without a latch edge");

  a_clear_drops: assert property ( // (R10)
    @(posedge core_clk) disable iff (rst)
    latchEdge && !shift_clear_n && !q.rdValid |=> !q.rdValid)
    else $error("latch edge taken during clear");

  a_snapshot_lands: assert property ( // (R1)
    @(posedge core_clk) disable iff (rst)
    q.wrValid && !q.rdValid |=> q.rdValid && q.rdData == $past(shift_reg))
    else $error("snapshot did not reach the queue head");

  a_dequeue_shows: assert property ( // (R7)
    @(posedge core_clk) disable iff (rst)
    q.rdValid && !latchHold |=> parallelOut == $past(q.rdData))
    else $error("dequeued word not shown on the outputs");

  a_hold_stalls: assert property ( // (R10)
    @(posedge core_clk) disable iff (rst)
    latchHold |=> $stable(store_reg))
    else $error("storage moved while held");

  a_full_stays: assert property ( // (R4)
    @(posedge core_clk) disable iff (rst)
    !q.wrReady && latchHold |=> !q.wrReady)
    else $error("full queue accepted a word");

  a_full_nonempty: assert property ( // (R4)
    @(posedge core_clk) disable iff (rst)
    !q.wrReady |-> q.rdValid)
    else $error("queue full and empty at once");
endmodule
`default_nettype wire

// *** test/serial_host_model.sv ***
// Purpose: Controller model driving serial data, clocks and clear
// Assumes: Pins change 1 ns after core_clk rises
// Notes:   Data line inverts once its pulse ends, no hold is promised
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
  // Clock
  input  wire logic core_clk,
  // Serial pins
  output var logic  data_in_line,
  output var logic  shift_clock,
  output var logic  latch_clock,
  output var logic  shift_clear_n
);
  initial begin
    data_in_line = 1'h0;
    shift_clock = 1'h0;
    latch_clock = 1'h0;
    shift_clear_n = 1'h1;
  end
  task automatic pulse(input logic sh, input logic la, input logic d);
    @(posedge core_clk);
    #1;
    data_in_line = d;
    shift_clock = sh;
    latch_clock = la;
    @(posedge core_clk);
    #1;
    shift_clock = 1'h0;
    latch_clock = 1'h0;
    data_in_line = ~d;
  endtask
  task automatic clear(input logic level);
    @(posedge core_clk);
    #1;
    shift_clear_n = level;
  endtask
endmodule
`default_nettype wire

// *** test/serial_in_parallel_out_latched_shifter_tb.sv ***
// Purpose: Self-checking bench for the latched shifter
// Assumes: Latched words appear two edges after the latch edge
// Notes:   Bits go in last bit first, so words read back unchanged
`timescale 1ns/1ps
`default_nettype none
module serial_in_parallel_out_latched_shifter_tb;
  import sipo_latch_pkg::*;
  logic              core_clk;
  logic              rst;
  logic              data_in_line;
  logic              shift_clock;
  logic              latch_clock;
  logic              shift_clear_n;
  logic              outEnable_n;
  logic              cascadeOut;
  logic              latchHold;
  logic              latchReady;
  logic [STAGES-1:0] parallelOut;
  logic [STAGES-1:0] parallelOe;
  int                badCount;
  int                cmpCount;
  int                cycles;
  localparam logic [7:0] LOAD_WORD = 8'hA5;
  serial_host_model hostModel (.core_clk(core_clk), .data_in_line(data_in_line), .shift_clock(shift_clock),
    .latch_clock(latch_clock), .shift_clear_n(shift_clear_n));
  sipo_latched_shifter dut (.core_clk(core_clk), .rst(rst), .data_in_line(data_in_line),
    .shift_clock(shift_clock), .latch_clock(latch_clock), .shift_clear_n(shift_clear_n),
    .outEnable_n(outEnable_n), .cascadeOut(cascadeOut), .parallelOut(parallelOut),
    .parallelOe(parallelOe), .latchHold(latchHold), .latchReady(latchReady));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      badCount++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic loadByte;
    for (int i = 7; i >= 0; i--) hostModel.pulse(1'h1, 1'h0, LOAD_WORD[i]);
    waitc(1);
    chk({7'h00, cascadeOut}, 8'h01);
    hostModel.pulse(1'h0, 1'h1, 1'h0);
    waitc(2);
    chk(parallelOut, LOAD_WORD);
  endtask
  task automatic tiedClocks;
    hostModel.pulse(1'h1, 1'h1, 1'h1);
    waitc(2);
    chk(parallelOut, 8'hA5);
    hostModel.pulse(1'h0, 1'h1, 1'h0);
    waitc(2);
    chk(parallelOut, 8'h4B);
  endtask
  task automatic outputGate;
    outEnable_n = 1'h1;
    waitc(2);
    chk(parallelOe, 8'h00);
    chk(parallelOut, 8'h4B);
    chk({7'h00, cascadeOut}, 8'h00);
    outEnable_n = 1'h0;
    waitc(2);
    chk(parallelOe, 8'hFF);
  endtask
  task automatic clearShift;
    hostModel.pulse(1'h1, 1'h0, 1'h1);
    chk({7'h00, cascadeOut}, 8'h01);
    hostModel.clear(1'h0);
    // Shift and latch edges during clear are both ignored
    hostModel.pulse(1'h1, 1'h1, 1'h1);
    waitc(1);
    chk({7'h00, cascadeOut}, 8'h00);
    chk(parallelOut, 8'h4B);
    hostModel.clear(1'h1);
    hostModel.pulse(1'h0, 1'h1, 1'h0);
    waitc(2);
    chk(parallelOut, 8'h00);
  endtask
  task automatic fillQueue;
    latchHold = 1'h1;
    // Tied pulses queue the old shift contents, ending in repeats of 55 and AA; the two past depth must be dropped
    for (int i = 0; i < FIFO_WORDS + 2; i++) hostModel.pulse(1'h1, 1'h1, ~i[0]);
    chk({7'h00, latchReady}, 8'h00);
    latchHold = 1'h0;
    waitc(2);
    chk(parallelOut, 8'h01);
    waitc(1);
    chk(parallelOut, 8'h02);
    waitc(1);
    chk(parallelOut, 8'h05);
    waitc(FIFO_WORDS);
    chk(parallelOut, 8'h55);
    chk({7'h00, latchReady}, 8'h01);
  endtask
  initial begin
    core_clk = 1'h0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 1000) begin
      badCount++;
      $display("mismatch at %0t: run too long", $time);
      conclude();
    end
  end
  initial begin
    rst = 1'h1;
    outEnable_n = 1'h0;
    latchHold = 1'h0;
    waitc(5);
    chk(parallelOut, STORE_RESET);
    rst = 1'h0;
    loadByte();
    tiedClocks();
    outputGate();
    clearShift();
    fillQueue();
    conclude();
  end
endmodule
`default_nettype wire
